/* File: core/rcm_regs.sv */
// Collision report and general mode registers with their effects.
// Assumes a one-cycle strobe register port and synchronous inputs.
// Summary of operation
// - Keep=0 clears bits after a collision
// - Invalid flag when none or out of range
// - Five-bit first collision position, data bits
// - Positions 1..31 literal, 32 reads 00h
// - High-first bit reverses checksum order
// - High-first bit ignored during RF
// - Sync bit: wait F0h, prepend F0h
// - Transmit start needs own field
// - Guard counter start needs external field
// - Signal input polarity from polarity bit
// - Internal envelope always active low
// - Polarity change raises activity event
// - Disable bit turns mode detector off
// - Mode detector only during anticollision command
// - Two-bit preset select table
// - During RF preset chosen automatically
// - Initiator bit selects initiator or target
//
// Design decision made here: strobed register access.
module rcm_regs
	import rcm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input rcm_pkg::rcm_bus_type bus,
	output logic [7:0] rdata,
	// Receiver side
	input rcm_pkg::rcm_rx_type rx,
	input wire logic rx_bit_value,
	output logic rx_bit_stored,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	output logic receiver_enable,
	// Transmit side
	input wire logic tx_request,
	output logic transmit_start,
	output logic prepend_sync,
	input wire logic antenna_driver_one_field_enable,
	input wire logic antenna_driver_two_field_enable,
	input wire logic initiator,
	output logic act_as_initiator,
	// Field and guard counter
	input wire logic external_field,
	input wire logic guard_request,
	output logic receive_guard_counter_start,
	// Signal input
	input wire logic external_signal_input,
	output logic envelope_n,
	output logic signal_input_activity_event,
	// Mode detector
	input wire logic automatic_anticollision_command,
	output logic mode_detector_enable,
	// Checksum unit
	input wire logic rf_active,
	input wire logic [15:0] auto_preset,
	input wire logic [15:0] checksum_raw,
	output logic checksum_high_bit_first_eff,
	output logic [15:0] checksum_preset,
	output logic [7:0] checksum_result_high,
	output logic [7:0] checksum_result_low
);
	import rcm_pkg::*;

	logic keep_bits_after_collision; // Collision report bit 7
	logic [7:0] mode; // General mode register
	logic [4:0] first_collision_position;
	logic collision_position_invalid;
	logic after_collision; // A collision was seen this frame
	logic sync_seen; // Sync byte arrived
	logic rd_coll, rd_mode; // Decoded read selects
	logic [15:0] checksum_rev;
	logic sync_byte_detect;
	logic wr_mode, wr_coll;

	assign wr_mode = bus.wr && bus.addr == MODE_OFFSET;
	assign wr_coll = bus.wr && bus.addr == COLL_REPORT_OFFSET;
	assign rd_coll = bus.rd && bus.addr == COLL_REPORT_OFFSET;
	assign rd_mode = bus.rd && bus.addr == MODE_OFFSET;
	assign sync_byte_detect = mode[MODE_SYNC_BIT];

	// ==========================================================
	// Collision tracker
	// Position and invalid flag are owned by the tracker alone
	rcm_coll_track u_track (
		.clk(clk),
		.resetn(resetn),
		.rx(rx),
		.position(first_collision_position),
		.invalid(collision_position_invalid),
		.after_collision(after_collision)
	);

	// ==========================================================
	// Writable bits; read-only fields take no write
	// Only the keep bit is stored here, the rest is tracker state
	always_ff @(posedge clk)
	begin
		if (!resetn)
			keep_bits_after_collision <= COLL_RESET[COLL_KEEP_BIT];
		else if (wr_coll)
			keep_bits_after_collision <= bus.wdata[COLL_KEEP_BIT];
	end

	// Whole mode byte is writable, preset select included
	always_ff @(posedge clk)
	begin
		if (!resetn)
			mode <= MODE_RESET;
		else if (wr_mode)
			mode <= bus.wdata;
	end

	// ==========================================================
	// Polarity change event, one cycle
	// Compared with the old bit, so rewriting the same value stays silent
	always_ff @(posedge clk)
	begin
		if (!resetn)
			signal_input_activity_event <= 1'b0;
		else
			signal_input_activity_event <= wr_mode
				&& bus.wdata[MODE_POL_BIT] != mode[MODE_POL_BIT];
	end

	// ==========================================================
	// Read port, data stands one cycle after the strobe
	// Registered from the pre-strobe state; unmapped and idle read zero
	// Reads have no side effect on any field
	always_ff @(posedge clk)
	begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd_coll)
			rdata <= {keep_bits_after_collision, 1'b0, collision_position_invalid,
				first_collision_position};
		else if (rd_mode)
			rdata <= mode;
		else
			rdata <= 8'h00;
	end

	// ==========================================================
	// Bits after a collision are zeroed unless kept
	// The collision bit itself keeps its value; only later bits clear
	always_comb
	begin
		rx_bit_stored = rx_bit_value;
		if (!keep_bits_after_collision && after_collision)
			rx_bit_stored = 1'b0;
	end

	// ==========================================================
	// Sync byte gate for the receiver
	// Waiting ends at the first sync byte of the frame
	// A sync byte beside frame_start is lost, the new frame wins
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sync_seen <= 1'b0;
		else if (rx.frame_start)
			sync_seen <= 1'b0;
		else if (rx_byte_valid && rx_byte == SYNC_BYTE)
			sync_seen <= 1'b1;
	end

	// Level outputs; the coder inserts the sync byte itself
	assign receiver_enable = !sync_byte_detect || sync_seen;
	assign prepend_sync = sync_byte_detect;

	// ==========================================================
	// Field gating of transmitter and guard counter
	// Gating applies only in the role the rule names; the other passes
	// Combinational, so a field drop blocks a start in the same cycle
	assign act_as_initiator = initiator;
	assign transmit_start = tx_request && (!(mode[MODE_TX_WAIT_BIT] && initiator)
		|| antenna_driver_one_field_enable || antenna_driver_two_field_enable);
	assign receive_guard_counter_start = guard_request
		&& (!(mode[MODE_RX_WAIT_BIT] && !initiator) || external_field);

	// ==========================================================
	// Signal input polarity to active-low envelope
	// XOR form: polarity 1 turns an active-high pin into active low
	assign envelope_n = mode[MODE_POL_BIT] ? !external_signal_input
		: external_signal_input;

	// ==========================================================
	// Mode detector gating
	// Disable bit wins even while the command runs
	assign mode_detector_enable = automatic_anticollision_command
		&& !mode[MODE_DET_OFF_BIT];

	// ==========================================================
	// Checksum order and preset
	// Order flag dropped during RF so a frame checksum never flips
	assign checksum_high_bit_first_eff = mode[MODE_HIGH_FIRST_BIT] && !rf_active;

	always_comb
	begin
		for (int i = 0; i < 16; i++)
			checksum_rev[i] = checksum_raw[15 - i];
	end

	// Result registers, reversed in high-first mode
	// Updated every cycle; the unit holds raw steady once it is done
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			checksum_result_high <= 8'h00;
			checksum_result_low <= 8'h00;
		end
		else if (checksum_high_bit_first_eff)
		begin
			checksum_result_high <= checksum_rev[15:8];
			checksum_result_low <= checksum_rev[7:0];
		end
		else
		begin
			checksum_result_high <= checksum_raw[15:8];
			checksum_result_low <= checksum_raw[7:0];
		end
	end

	// Preset select sits in the two low mode bits
	// Auto preset passes through untouched while RF runs
	rcm_preset_sel u_preset (
		.sel(mode[1:0]),
		.rf_active(rf_active),
		.auto_preset(auto_preset),
		.preset(checksum_preset)
	);

	// ==========================================================
	// Checks
	// Assertions watch the bank's outputs against the rules
	sequence s_pol_write;
		wr_mode && bus.wdata[MODE_POL_BIT] != mode[MODE_POL_BIT];
	endsequence

	sequence s_coll_read;
		bus.rd && bus.addr == COLL_REPORT_OFFSET;
	endsequence

	// Polarity event
	a_pol_change_event: assert property (@(posedge clk) disable iff (!resetn)
		s_pol_write |=> signal_input_activity_event)
		else $error("polarity change lost event");
	a_no_spurious_event: assert property (@(posedge clk) disable iff (!resetn)
		signal_input_activity_event |-> $changed(mode[MODE_POL_BIT]))
		else $error("event without polarity change");
	a_event_needs_write: assert property (@(posedge clk) disable iff (!resetn)
		!wr_mode |=> !signal_input_activity_event)
		else $error("event without mode write");

	// Collision report
	a_clear_after_coll: assert property (@(posedge clk) disable iff (!resetn)
		after_collision && !keep_bits_after_collision |-> !rx_bit_stored)
		else $error("bit kept after collision");
	a_keep_write: assert property (@(posedge clk) disable iff (!resetn)
		wr_coll |=> keep_bits_after_collision == $past(bus.wdata[COLL_KEEP_BIT]))
		else $error("keep bit write lost");
	a_coll_readonly: assert property (@(posedge clk) disable iff (!resetn)
		wr_coll && !rx.data_bit && !rx.frame_start
		|=> $stable(first_collision_position) && $stable(collision_position_invalid))
		else $error("read-only field written");
	a_coll_readback: assert property (@(posedge clk) disable iff (!resetn)
		s_coll_read |=> rdata == {$past(keep_bits_after_collision), 1'b0,
		$past(collision_position_invalid), $past(first_collision_position)})
		else $error("collision report read wrong");

	// Field gating, sync and detector
	a_tx_field_gate: assert property (@(posedge clk) disable iff (!resetn)
		transmit_start && mode[MODE_TX_WAIT_BIT] && initiator
		|-> antenna_driver_one_field_enable || antenna_driver_two_field_enable)
		else $error("transmit without own field");
	a_guard_field_gate: assert property (@(posedge clk) disable iff (!resetn)
		receive_guard_counter_start && mode[MODE_RX_WAIT_BIT] && !initiator
		|-> external_field)
		else $error("guard counter without field");
	a_detector_gate: assert property (@(posedge clk) disable iff (!resetn)
		mode_detector_enable |-> automatic_anticollision_command
		&& !mode[MODE_DET_OFF_BIT])
		else $error("mode detector active wrongly");
	a_envelope_polarity: assert property (@(posedge clk) disable iff (!resetn)
		envelope_n == (external_signal_input ^ mode[MODE_POL_BIT]))
		else $error("envelope polarity wrong");
	a_sync_wait: assert property (@(posedge clk) disable iff (!resetn)
		sync_byte_detect && rx.frame_start && !wr_mode |=> !receiver_enable)
		else $error("receiver on before sync");

	// Checksum order and preset
	a_rf_no_reverse: assert property (@(posedge clk) disable iff (!resetn)
		rf_active |=> checksum_result_high == $past(checksum_raw[15:8]))
		else $error("order reversed during RF");
	a_high_first_order: assert property (@(posedge clk) disable iff (!resetn)
		checksum_high_bit_first_eff |=> checksum_result_high[7] == $past(checksum_raw[0])
		&& checksum_result_low[0] == $past(checksum_raw[15]))
		else $error("checksum order not reversed");
	a_preset_auto: assert property (@(posedge clk) disable iff (!resetn)
		rf_active |-> checksum_preset == auto_preset)
		else $error("preset not automatic");
	a_preset_table: assert property (@(posedge clk) disable iff (!resetn)
		!rf_active && mode[1:0] == 2'b10 |-> checksum_preset == PRESET_2)
		else $error("preset table wrong");

endmodule // rcm_regs

/* File: core/rcm_pkg.sv */
// Package for the collision report and general mode register bank.
// Assumes one 125 MHz clock and a plain strobe register port.
package rcm_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [15:0] COLL_REPORT_OFFSET = 16'h00ef; // Collision report
	localparam logic [15:0] MODE_OFFSET = 16'h6301; // General tx/rx mode

	// ==========================================================
	// Collision report field positions
	localparam int COLL_KEEP_BIT = 7; // Keep bits after collision
	localparam int COLL_INVALID_BIT = 5; // Position invalid flag
	localparam logic [7:0] COLL_RESET = 8'ha0; // Keep=1, invalid=1

	// ==========================================================
	// Mode register field positions
	localparam int MODE_HIGH_FIRST_BIT = 7;
	localparam int MODE_SYNC_BIT = 6;
	localparam int MODE_TX_WAIT_BIT = 5;
	localparam int MODE_RX_WAIT_BIT = 4;
	localparam int MODE_POL_BIT = 3;
	localparam int MODE_DET_OFF_BIT = 2;
	localparam logic [7:0] MODE_RESET = 8'h3b;

	// ==========================================================
	// Checksum presets and sync byte
	localparam logic [15:0] PRESET_0 = 16'h0000;
	localparam logic [15:0] PRESET_1 = 16'h6363;
	localparam logic [15:0] PRESET_2 = 16'ha671;
	localparam logic [15:0] PRESET_3 = 16'hffff;
	localparam logic [7:0] SYNC_BYTE = 8'hf0;

	// Collision position counter range (32 data bits fit the field)
	localparam logic [5:0] COLL_POS_LIMIT = 6'h20;

	// Register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rcm_bus_type;

	// Receiver collision report
	typedef struct packed {
		logic frame_start; // New frame, clears report
		logic data_bit; // One data bit received
		logic collision; // Collision on that bit
	} rcm_rx_type;

endpackage

/* File: core/rcm_coll_track.sv */
// Tracks first collision position of a received frame.
// Assumes receiver strobes are synchronous and one cycle long.
module rcm_coll_track
	import rcm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Receiver events
	input rcm_pkg::rcm_rx_type rx,
	// Report
	output logic [4:0] position,
	output logic invalid,
	output logic after_collision
);
	logic [5:0] bit_count; // Data bits seen so far
	logic [5:0] next_count;

	assign next_count = bit_count + 6'h01;

	// ==========================================================
	// Count data bits, capture the first collision
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			bit_count <= 6'h00;
			position <= 5'h00;
			invalid <= 1'b1;
			after_collision <= 1'b0;
		end
		else if (rx.frame_start)
		begin
			// No collision yet in the new frame
			bit_count <= 6'h00;
			invalid <= 1'b1;
			after_collision <= 1'b0;
		end
		else if (rx.data_bit)
		begin
			if (bit_count != 6'h3f)
				bit_count <= next_count;
			if (rx.collision && !after_collision)
			begin
				after_collision <= 1'b1;
				// Bit 32 wraps to zero by truncation
				position <= next_count[4:0];
				// Compare the saturated count, the sum wraps past 63 bits
				invalid <= (bit_count >= COLL_POS_LIMIT);
			end
		end
	end

	a_first_coll_pos: assert property (@(posedge clk) disable iff (!resetn)
		rx.data_bit && rx.collision && !after_collision && !rx.frame_start
		&& bit_count < COLL_POS_LIMIT
		|=> position == 5'($past(bit_count) + 6'h01) && !invalid)
		else $error("collision position wrong");

endmodule // rcm_coll_track

/* File: core/rcm_preset_sel.sv */
// Chooses the checksum preset from the select field or auto mode.
// Assumes auto preset comes from the transmit/receive mode logic.
module rcm_preset_sel
	import rcm_pkg::*;
(
	// Selection
	input wire logic [1:0] sel,
	input wire logic rf_active,
	input wire logic [15:0] auto_preset,
	// Result
	output logic [15:0] preset
);
	// ==========================================================
	// Preset table, bypassed while RF is busy
	always_comb
	begin
		if (rf_active)
			preset = auto_preset;
		else
		begin
			case (sel)
				2'b00: preset = PRESET_0;
				2'b01: preset = PRESET_1;
				2'b10: preset = PRESET_2;
				default: preset = PRESET_3;
			endcase
		end
	end

endmodule // rcm_preset_sel

/* File: dv/rcm_rx_model.sv */
// Receiver front-end model: sends frames of data bits into the bank.
// Assumes the bench pulses go for one cycle and then waits on busy.
module rcm_rx_model
	import rcm_pkg::*;
(
	// Clock
	input wire logic clk,
	// Frame request from the bench
	input wire logic go,
	input wire logic [6:0] nbits,
	input wire logic [6:0] cpos,
	// Receiver events
	output rcm_pkg::rcm_rx_type rx,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import rcm_pkg::*;

	// ======
	// Frame sender
	// Every bit from cpos on collides, so later collisions must be ignored
	initial
	begin
		rx <= '0;
		busy <= 1'b0;
		forever
		begin
			@(posedge clk);
			if (go)
			begin
				busy <= 1'b1;
				rx <= 3'b100;
				for (int n = 1; n <= nbits; n++)
				begin
					@(posedge clk);
					rx <= {2'b01, cpos != 0 && n >= cpos};
				end
				@(posedge clk);
				rx <= '0;
				busy <= 1'b0;
			end
		end
	end
endmodule // rcm_rx_model

/* File: dv/rcm_regs_test.sv */
// Self-checking bench for the collision report and mode register bank.
// Assumes the receiver model beside it; side inputs are driven at random, the bus by the tasks.
module rcm_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rcm_pkg::*;

	// ======
	// Signals
	logic clk, resetn, go, busy, bitv, bits, rbv, rxen, txreq, tx_start, psync, a1, a2, init;
	logic act, fld, greq, gstart, sig, env, evt, cmd, mde, rf, eff;
	rcm_bus_type bus;
	rcm_rx_type rx;
	logic [7:0] rdata, rx_byte, hi, lo;
	logic [15:0] auto_p, raw, preset;
	logic [6:0] nbits, cpos;
	int fail_count, check_count;
	// Reference model state
	logic [7:0] m_mode, m_rd, m_mask;
	logic [15:0] m_res;
	logic [4:0] m_pos;
	logic m_keep, m_inv, m_seen, m_sync, m_evt, m_rdv;
	int m_cnt;
	logic [15:0] presets [4] = '{PRESET_0, PRESET_1, PRESET_2, PRESET_3};
	// Frame table: bit count and first collision bit (0 = none)
	int fb [7] = '{10, 12, 40, 40, 20, 40, 32};
	int fc [7] = '{1, 8, 32, 33, 0, 5, 31};

	// ======
	// Instances
	rcm_regs DUT (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .rx(rx),
		.rx_bit_value(bitv), .rx_bit_stored(bits), .rx_byte(rx_byte), .rx_byte_valid(rbv),
		.receiver_enable(rxen), .tx_request(txreq), .transmit_start(tx_start),
		.prepend_sync(psync), .antenna_driver_one_field_enable(a1),
		.antenna_driver_two_field_enable(a2), .initiator(init), .act_as_initiator(act),
		.external_field(fld), .guard_request(greq), .receive_guard_counter_start(gstart),
		.external_signal_input(sig), .envelope_n(env), .signal_input_activity_event(evt),
		.automatic_anticollision_command(cmd), .mode_detector_enable(mde), .rf_active(rf),
		.auto_preset(auto_p), .checksum_raw(raw), .checksum_high_bit_first_eff(eff),
		.checksum_preset(preset), .checksum_result_high(hi), .checksum_result_low(lo));
	rcm_rx_model RXM (.clk(clk), .go(go), .nbits(nbits), .cpos(cpos), .rx(rx), .busy(busy));

	// ======
	// Clock, 8 ns period
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Random side inputs every cycle, sync byte made frequent on purpose
	always @(posedge clk)
	begin
		{txreq, a1, a2, init, fld, greq, sig, cmd, rf, bitv, rbv} <= 11'($urandom);
		auto_p <= 16'($urandom);
		raw <= 16'($urandom);
		rx_byte <= ($urandom % 4 == 0) ? SYNC_BYTE : 8'($urandom);
	end

	// ======
	// Reference model, updated on the same edge as the design
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			{m_mode, m_keep, m_inv, m_pos, m_seen, m_sync} = {MODE_RESET, 2'b11, 7'h00};
			{m_evt, m_rdv, m_res, m_cnt} = '0;
			{m_rd, m_mask} = '0;
		end
		else
		begin
			m_evt = bus.wr && bus.addr == MODE_OFFSET && bus.wdata[3] != m_mode[3];
			for (int i = 0; i < 16; i++)
				m_res[i] = (m_mode[7] && !rf) ? raw[15 - i] : raw[i];
			if (bus.wr && bus.addr == MODE_OFFSET)
				m_mode = bus.wdata;
			if (bus.wr && bus.addr == COLL_REPORT_OFFSET)
				m_keep = bus.wdata[7];
			if (rx.frame_start)
				{m_cnt, m_seen, m_inv, m_sync} = {32'd0, 3'b010};
			else
			begin
				if (rbv && rx_byte == SYNC_BYTE)
					m_sync = 1'b1;
				if (rx.data_bit)
					m_cnt++;
				if (rx.data_bit && rx.collision && !m_seen)
					{m_seen, m_inv, m_pos} = {1'b1, m_cnt > 32, 5'(m_cnt)};
			end
			m_rdv = bus.rd;
			// Position only counts while the invalid flag is clear
			m_mask = (bus.addr == COLL_REPORT_OFFSET && m_inv) ? 8'he0 : 8'hff;
			m_rd = (bus.addr == MODE_OFFSET) ? m_mode : 8'h00;
			if (bus.addr == COLL_REPORT_OFFSET)
				m_rd = {m_keep, 1'b0, m_inv, m_pos};
		end
	end

	// Compare every output once a cycle, the stored bit on data bits only, mid-cycle where all is settled
	always @(negedge clk)
		if (resetn)
		begin
			if (rx.data_bit)
				check(bits, (!m_keep && m_seen) ? 1'b0 : bitv);
			check(rxen, !m_mode[6] || m_sync);
			check(psync, m_mode[6]);
			check(tx_start, txreq && (!(m_mode[5] && init) || a1 || a2));
			check(act, init);
			check(gstart, greq && (!(m_mode[4] && !init) || fld));
			check(env, sig ^ m_mode[3]);
			check(evt, m_evt);
			check(mde, cmd && !m_mode[2]);
			check(eff, m_mode[7] && !rf);
			check(preset, rf ? auto_p : presets[m_mode[1:0]]);
			check({hi, lo}, m_res);
			check(rdata & m_mask, m_rdv ? m_rd & m_mask : 8'h00);
		end

	// ======
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle strobes; an edge always passes before the next one
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= {a, d, 2'b10};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		bus <= {a, 8'h00, 2'b01};
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask

	// Send one frame and wait for it under a bound
	task automatic frame(input int nb, input int cp);
		@(posedge clk);
		{nbits, cpos, go} <= {7'(nb), 7'(cp), 1'b1};
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (int k = 0; busy && k < 100; k++)
			@(posedge clk);
		if (busy)
			fail_count++;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ======
	// Main sequence
	initial
	begin
		{resetn, go, nbits, cpos, bus, fail_count, check_count} = '0;
		void'($urandom(92));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(COLL_REPORT_OFFSET);
		rd(MODE_OFFSET);
		$display("test reset values done");
		// Every preset code, random upper bits flip polarity and gating
		for (int i = 0; i < 16; i++)
		begin
			wr(MODE_OFFSET, {6'($urandom), 2'(i)});
			rd(MODE_OFFSET);
		end
		$display("test mode register done");
		// Frames below stand for a peer exchange, so sync is on
		wr(MODE_OFFSET, {2'b01, 6'($urandom)});
		// Clear after collision, read-only bits poked with ones
		wr(COLL_REPORT_OFFSET, 8'h7f);
		for (int i = 0; i < 7; i++)
		begin
			frame(fb[i], fc[i]);
			rd(COLL_REPORT_OFFSET);
		end
		wr(COLL_REPORT_OFFSET, 8'h80);
		frame(12, 3);
		rd(COLL_REPORT_OFFSET);
		// Sync back off outside the peer exchange
		wr(MODE_OFFSET, MODE_RESET);
		$display("test collision report done");
		// Unmapped place reads zero and leaves the bank alone
		wr(16'h1234, 8'h5a);
		rd(16'h1234);
		rd(MODE_OFFSET);
		$display("test unmapped access done");
		final_report;
	end

	// Watchdog: the tests need well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report;
	end
endmodule // rcm_regs_test
